// file: art_map.svh
/*
  Register indices, field positions, reset values and widths of the auto-reload timer.
  Assumes it is included by its bare name; byte address of a register is four times its index.
*/
`ifndef ART_MAP_SVH
`define ART_MAP_SVH

// ********************************************************************
// Register indices
// ********************************************************************
`define ART_MODE_IDX        24'hffffb4
`define ART_COUNT_IDX       24'hffffb5
`define ART_STAT_IDX        24'hffffb6
`define ART_MASK_IDX        24'hffffb7

// ********************************************************************
// Field positions
// ********************************************************************
`define ART_MODE_RELOAD_BIT 7
`define ART_MODE_DIR_HI     6
`define ART_MODE_DIR_LO     5
`define ART_MODE_FIXED_BIT  4
`define ART_MODE_CLK_HI     3
`define ART_MODE_CLK_LO     0
`define ART_STAT_IRQ_BIT    0

// ********************************************************************
// Reset values, count limits and widths
// ********************************************************************
`define ART_MODE_RESET      8'h10
`define ART_COUNT_RESET     8'h00
`define ART_RELOAD_RESET    8'h00
`define ART_COUNT_MAX       8'hff
`define ART_COUNT_MIN       8'h00
`define ART_PRESCALER_W     17
`define ART_SUBDIV_W        10

`endif

// file: art_pkg.sv
/*
  Types shared by the auto-reload timer modules.
  Assumes art_map.svh is on the include path.
*/
package art_pkg;

  typedef logic [7:0] art_byte_t;

  typedef enum logic [1:0]
  {
    ART_CNT_UP   = 2'b01,
    ART_CNT_DOWN = 2'b10
  } art_dir_t;

  typedef enum logic [2:0]
  {
    ART_BUS_IDLE = 3'b001,
    ART_BUS_WAIT = 3'b010,
    ART_BUS_DONE = 3'b100
  } art_bus_t;

endpackage

// file: art_tick_if.sv
/*
  Carrier between the timer core and its tick generator: clock select out, count tick back.
  Assumes both ends run on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

interface art_tick_if;
  logic [3:0] clk_sel;
  logic       tick;

  modport ctl (output clk_sel, input tick);
  modport gen (input clk_sel, output tick);
endinterface

`default_nettype wire

// file: art_tick_gen.sv
/*
  Prescaler, subclock divider, external edge detector and clock-source multiplexer.
  Assumes sub_clk and the event input are synchronous to clk_sys and far slower than it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "art_map.svh"

module art_tick_gen
  import art_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic sub_clk,
  input  wire logic external_event_input,
  art_tick_if.gen   tick_if
);

  localparam int TAP_BITS [6] = '{13, 11, 9, 6, 4, 2};

  logic [`ART_PRESCALER_W-1:0] sys_prescaler;
  logic [`ART_SUBDIV_W-1:0]    sub_div;
  logic                        sub_q;
  logic                        ext_q;
  logic [5:0]                  sys_tap;
  logic                        sub_rise;
  logic                        ext_rise;
  logic                        ext_fall;
  logic                        next_tick;

  // ********************************************************************
  // Prescaler
  // ********************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sys_prescaler <= '0;
    else
      sys_prescaler <= sys_prescaler + 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_tap
      assign sys_tap[g] = &sys_prescaler[TAP_BITS[g]-1:0];
    end
  endgenerate

  // ********************************************************************
  // Subclock divider and edge detection
  // ********************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sub_q <= 1'b0;
      ext_q <= 1'b0;
    end
    else
    begin
      sub_q <= sub_clk;
      ext_q <= external_event_input;
    end
  end

  assign sub_rise = sub_clk & ~sub_q;
  assign ext_rise = external_event_input & ~ext_q;
  assign ext_fall = ~external_event_input & ext_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sub_div <= '0;
    else if (sub_rise)
      sub_div <= sub_div + 1'b1;
  end

  // ********************************************************************
  // Source selection
  // ********************************************************************
  always_comb
  begin
    next_tick = 1'b0;
    unique casez (tick_if.clk_sel)
      4'b?000: next_tick = sys_tap[0];
      4'b?001: next_tick = sys_tap[1];
      4'b?010: next_tick = sys_tap[2];
      4'b?011: next_tick = sys_tap[3];
      4'b?100: next_tick = sys_tap[4];
      4'b0101: next_tick = sys_tap[5];
      4'b0110: next_tick = sub_rise & (&sub_div[9:0]);
      4'b1101: next_tick = sub_rise & (&sub_div[7:0]);
      4'b1110: next_tick = sub_rise & (&sub_div[1:0]);
      4'b0111: next_tick = ext_fall;
      4'b1111: next_tick = ext_rise;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tick_if.tick <= 1'b0;
    else
      tick_if.tick <= next_tick;
  end

endmodule // art_tick_gen

`default_nettype wire

// file: art_timer.sv
/*
  Auto-reload 8-bit up/down timer with an APB register port and a level interrupt.
  Assumes an APB master on clk_sys, synchronous pins, and the processor interrupt mask as a level.
*/
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "art_map.svh"

module art_timer
  import art_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        sub_clk,
  input  wire logic        external_event_input,
  input  wire logic        count_direction_pin,
  input  wire logic        cpu_irq_mask,
  output var  logic        timer_irq
);

  // ********************************************************************
  // Decoding helpers
  // ********************************************************************
  function automatic logic addr_hit(input logic [31:0] addr, input logic [23:0] idx);
    addr_hit = (addr == {6'h00, idx, 2'b00});
  endfunction

  function automatic art_dir_t pick_dir(input logic [1:0] dir_sel, input logic pin);
    if (dir_sel[1])
    begin
      pick_dir = pin ? ART_CNT_DOWN : ART_CNT_UP;
    end
    else if (dir_sel[0])
    begin
      pick_dir = ART_CNT_DOWN;
    end
    else
    begin
      pick_dir = ART_CNT_UP;
    end
  endfunction

  // ********************************************************************
  // Declarations
  // ********************************************************************
  art_tick_if  tick_bus ();

  art_byte_t   timer_mode_control;
  art_byte_t   count_value;
  art_byte_t   reload_value;
  logic        timer_irq_flag;
  logic        timer_irq_enable;
  art_bus_t    bus_state;
  art_bus_t    next_bus_state;
  logic        access;
  logic        wr_take;
  logic        hit_mode;
  logic        hit_count;
  logic        hit_stat;
  logic        hit_mask;
  logic        hit_any;
  logic        wr_mode;
  logic        wr_count;
  logic        wr_stat;
  logic        wr_mask;
  logic        reload_mode;
  art_dir_t    count_dir;
  logic        at_max;
  logic        at_min;
  logic        wrap_up;
  logic        wrap_down;
  logic        wrap_event;
  art_byte_t   next_count;
  logic [31:0] next_prdata;

  // ********************************************************************
  // Tick generator
  // ********************************************************************
  assign tick_bus.clk_sel = timer_mode_control[`ART_MODE_CLK_HI:`ART_MODE_CLK_LO];

  art_tick_gen u_tick_gen
  (
    .clk_sys              (clk_sys),
    .rst_n                (rst_n),
    .sub_clk              (sub_clk),
    .external_event_input (external_event_input),
    .tick_if              (tick_bus)
  );

  // ********************************************************************
  // APB handshake
  // ********************************************************************
  assign access    = psel & penable;
  assign wr_take   = access & pready & pwrite;
  assign hit_mode  = addr_hit(paddr, `ART_MODE_IDX);
  assign hit_count = addr_hit(paddr, `ART_COUNT_IDX);
  assign hit_stat  = addr_hit(paddr, `ART_STAT_IDX);
  assign hit_mask  = addr_hit(paddr, `ART_MASK_IDX);
  assign hit_any   = hit_mode | hit_count | hit_stat | hit_mask;
  assign wr_mode   = wr_take & hit_mode & pstrb[0];
  assign wr_count  = wr_take & hit_count & pstrb[0];
  assign wr_stat   = wr_take & hit_stat & pstrb[0];
  assign wr_mask   = wr_take & hit_mask & pstrb[0];

  always_comb
  begin
    next_bus_state = bus_state;
    unique case (bus_state)
      ART_BUS_IDLE:
      begin
        if (access)
          next_bus_state = ART_BUS_WAIT;
      end
      ART_BUS_WAIT:
      begin
        next_bus_state = ART_BUS_DONE;
      end
      ART_BUS_DONE:
      begin
        next_bus_state = ART_BUS_IDLE;
      end
      default:
      begin
        next_bus_state = ART_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      bus_state <= ART_BUS_IDLE;
    else
      bus_state <= next_bus_state;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= access & (bus_state == ART_BUS_IDLE);
    end
  end

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit_mode)
    begin
      next_prdata = {24'h00_0000, timer_mode_control};
    end
    else if (hit_count)
    begin
      next_prdata = {24'h00_0000, count_value};
    end
    else if (hit_stat)
    begin
      next_prdata = {31'h0000_0000, timer_irq_flag};
    end
    else if (hit_mask)
    begin
      next_prdata = {31'h0000_0000, timer_irq_enable};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (access & (bus_state == ART_BUS_IDLE))
    begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= ~hit_any;
    end
    else if (bus_state == ART_BUS_WAIT)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // ********************************************************************
  // Mode register
  // ********************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      timer_mode_control <= `ART_MODE_RESET;
    else if (wr_mode)
    begin
      timer_mode_control <= pwpdata_mode(pwdata[7:0]);
    end
  end

  function automatic art_byte_t pwpdata_mode(input art_byte_t wdata);
    pwpdata_mode = wdata;
    pwpdata_mode[`ART_MODE_FIXED_BIT] = 1'b1;
  endfunction

  assign reload_mode = timer_mode_control[`ART_MODE_RELOAD_BIT];
  assign count_dir   = pick_dir(timer_mode_control[`ART_MODE_DIR_HI:`ART_MODE_DIR_LO],
                                count_direction_pin);

  // ********************************************************************
  // Reload register
  // ********************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reload_value <= `ART_RELOAD_RESET;
    end
    else if (wr_count)
    begin
      reload_value <= pwdata[7:0];
    end
  end

  // ********************************************************************
  // Counter
  // ********************************************************************
  assign at_max     = (count_value == `ART_COUNT_MAX);
  assign at_min     = (count_value == `ART_COUNT_MIN);
  assign wrap_up    = tick_bus.tick & (count_dir == ART_CNT_UP) & at_max;
  assign wrap_down  = tick_bus.tick & (count_dir == ART_CNT_DOWN) & at_min;
  assign wrap_event = (wrap_up | wrap_down) & ~wr_count;

  always_comb
  begin
    next_count = count_value;
    if (wr_count)
    begin
      next_count = pwdata[7:0];
    end
    else if (tick_bus.tick)
    begin
      if (wrap_up | wrap_down)
      begin
        if (reload_mode)
        begin
          next_count = reload_value;
        end
        else
        begin
          next_count = wrap_up ? `ART_COUNT_MIN : `ART_COUNT_MAX;
        end
      end
      else if (count_dir == ART_CNT_UP)
      begin
        next_count = count_value + 8'h01;
      end
      else
      begin
        next_count = count_value - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_value <= `ART_COUNT_RESET;
    end
    else
    begin
      count_value <= next_count;
    end
  end

  // ********************************************************************
  // Interrupt flag, enable and output
  // ********************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_irq_flag <= 1'b0;
    end
    else if (wrap_event)
    begin
      timer_irq_flag <= 1'b1;
    end
    else if (wr_stat & pwdata[`ART_STAT_IRQ_BIT])
    begin
      timer_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_irq_enable <= 1'b0;
    end
    else if (wr_mask)
    begin
      timer_irq_enable <= pwdata[`ART_STAT_IRQ_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_irq <= 1'b0;
    end
    else
    begin
      timer_irq <= timer_irq_flag & timer_irq_enable & ~cpu_irq_mask;
    end
  end

endmodule // art_timer

`default_nettype wire

// file: art_timer_properties.sv
/*
  Port checker of the auto-reload timer.
  Assumes it is bound onto art_timer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "art_map.svh"

module art_timer_properties
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpu_irq_mask,
  input wire logic        timer_irq
);
  localparam logic [31:0] AM = {6'h00, `ART_MODE_IDX, 2'b00};
  localparam logic [31:0] AC = {6'h00, `ART_COUNT_IDX, 2'b00};
  localparam logic [31:0] AS = {6'h00, `ART_STAT_IDX, 2'b00};
  localparam logic [31:0] AE = {6'h00, `ART_MASK_IDX, 2'b00};
  logic mapped;

  assign mapped = (paddr == AM) || (paddr == AC) || (paddr == AS) || (paddr == AE);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence access_start;
    psel && !penable ##1 psel && penable;
  endsequence

  chk_ready_after_access: assert property (access_start |=> pready)
    else $error("no answer one cycle after access");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_ready_has_cause: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  chk_err_on_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("error flag wrong for address");
  chk_err_data_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("error read returned data");
  chk_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  chk_mode_fixed_bit: assert property (pready && !pwrite && paddr == AM |-> prdata[4] && prdata[31:8] == 24'h0)
    else $error("mode fixed bit not one");
  chk_irq_masked_off: assert property ($past(cpu_irq_mask) |-> !timer_irq)
    else $error("interrupt while masked");
endmodule // art_timer_properties

`default_nettype wire

// file: art_timer_tb.sv
/*
  Self-checking bench of the auto-reload timer.
  Assumes art_pkg, art_map.svh and the checker are compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "art_map.svh"

module art_timer_tb;
  localparam logic [31:0] AM = {6'h00, `ART_MODE_IDX, 2'b00};
  localparam logic [31:0] AC = {6'h00, `ART_COUNT_IDX, 2'b00};
  localparam logic [31:0] AS = {6'h00, `ART_STAT_IDX, 2'b00};
  localparam logic [31:0] AE = {6'h00, `ART_MASK_IDX, 2'b00};
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        sub_clk, ev, dir_pin, mask, irq, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  int          fail_count, samples_checked;

  art_timer u_art_timer (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sub_clk(sub_clk), .external_event_input(ev),
    .count_direction_pin(dir_pin), .cpu_irq_mask(mask), .timer_irq(irq));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Bus, stimulus and compare tasks
  // ****************************************
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(nm, exp, rd);
  endtask

  task automatic pulse(input int n);
    repeat (n)
    begin
      ev <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ev <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask

  task automatic sub_pulses(input int n);
    repeat (n)
    begin
      sub_clk <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sub_clk <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask

  task automatic ext_case(input logic [7:0] md, input logic pin, input logic [7:0] rl, input int n,
                          input logic [7:0] exp);
    bus(1'b1, AM, md);
    dir_pin <= pin;
    bus(1'b1, AC, rl);
    bus(1'b1, AS, 8'h01);
    pulse(n);
    rdchk("ext count", AC, {24'h0, exp});
    rdchk("ext flag", AS, 32'h1);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rdchk("mode reset", AM, 32'h10);
    rdchk("count reset", AC, 32'h0);
    rdchk("flag reset", AS, 32'h0);
    bus(1'b1, AE + 32'h4, 8'hff);
    chk("write error", 32'h1, {31'h0, er});
    rdchk("bad read", AE + 32'h4, 32'h0);
    chk("read error", 32'h1, {31'h0, er});
    bus(1'b1, AM, 8'h65);
    rdchk("mode rw", AM, 32'h75);
    bus(1'b1, AM, 8'h0f);
    rdchk("mode stop", AM, 32'h1f);
    pstrb <= 4'h0;
    bus(1'b1, AM, 8'h80);
    pstrb <= 4'hf;
    rdchk("strobe off", AM, 32'h1f);
    bus(1'b1, AC, 8'h5a);
    rdchk("reload load", AC, 32'h5a);
    $display("done reset and registers");
  endtask

  task automatic t_ext;
    ext_case(8'h4f, 1'b0, 8'hfe, 2, 8'h00);
    ext_case(8'h4f, 1'b1, 8'h01, 2, 8'hff);
    ext_case(8'h2f, 1'b0, 8'h10, 17, 8'hff);
    ext_case(8'h0f, 1'b1, 8'hff, 1, 8'h00);
    ext_case(8'hcf, 1'b0, 8'hfe, 2, 8'hfe);
    ext_case(8'hef, 1'b1, 8'h00, 1, 8'h00);
    ext_case(8'h47, 1'b1, 8'h02, 3, 8'hff);
    $display("done external events");
  endtask

  task automatic t_sub;
    bus(1'b1, AM, 8'h0e);
    bus(1'b1, AC, 8'h10);
    sub_pulses(8);
    rdchk("sub count", AC, 32'h12);
    bus(1'b1, AM, 8'h0d);
    bus(1'b1, AC, 8'h20);
    sub_pulses(256);
    rdchk("sub 256", AC, 32'h21);
    bus(1'b1, AM, 8'h06);
    bus(1'b1, AC, 8'h30);
    sub_pulses(1024);
    rdchk("sub 1024", AC, 32'h31);
    bus(1'b1, AM, 8'h03);
    bus(1'b1, AC, 8'h00);
    repeat (640) @(posedge clk_sys);
    bus(1'b0, AC, 8'h00);
    chk("sys 64", 32'h1, {31'h0, rd[7:0] >= 8'h0a && rd[7:0] <= 8'h0b});
    bus(1'b1, AM, 8'h0f);
    $display("done subclock");
  endtask

  task automatic t_auto;
    logic big;
    big = 1'b0;
    bus(1'b1, AM, 8'ha5);
    bus(1'b1, AC, 8'h02);
    bus(1'b1, AS, 8'h01);
    repeat (10)
    begin
      bus(1'b0, AC, 8'h00);
      chk("auto range", 32'h1, {31'h0, rd[7:0] <= 8'h02});
    end
    rdchk("auto flag", AS, 32'h1);
    bus(1'b1, AM, 8'h25);
    bus(1'b1, AC, 8'h02);
    repeat (10)
    begin
      bus(1'b0, AC, 8'h00);
      big = big | (rd[7:0] > 8'h02);
    end
    chk("free wrap", 32'h1, {31'h0, big});
    bus(1'b1, AM, 8'h0f);
    $display("done auto-reload");
  endtask

  task automatic t_irq;
    bus(1'b1, AC, 8'hff);
    bus(1'b1, AS, 8'h01);
    bus(1'b1, AE, 8'h01);
    rdchk("enable rw", AE, 32'h1);
    chk("irq idle", 32'h0, {31'h0, irq});
    pulse(1);
    chk("irq on", 32'h1, {31'h0, irq});
    mask <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("irq masked", 32'h0, {31'h0, irq});
    mask <= 1'b0;
    bus(1'b1, AE, 8'h00);
    repeat (3) @(posedge clk_sys);
    chk("irq disabled", 32'h0, {31'h0, irq});
    bus(1'b1, AE, 8'h01);
    repeat (3) @(posedge clk_sys);
    chk("irq again", 32'h1, {31'h0, irq});
    bus(1'b1, AS, 8'h01);
    repeat (3) @(posedge clk_sys);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("done interrupt");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    give_verdict;
  end

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    sub_clk = 1'b0;
    ev = 1'b0;
    dir_pin = 1'b0;
    mask = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_ext;
    t_sub;
    t_auto;
    t_irq;
    give_verdict;
  end
endmodule // art_timer_tb

bind art_timer art_timer_properties u_art_timer_properties (.clk_sys(clk_sys), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cpu_irq_mask(cpu_irq_mask), .timer_irq(timer_irq));

`default_nettype wire
